// ===== core/mode_sense_log_responder.sv
// mode sense and smart log page responder with apb register access
//
// Overview of operation
// RL1: smart log page code 2Fh, length 8, one parameter 0000h of length 04h.
// RL2: log bytes 8-11: sense code, qualifier, latest temperature, trip point.
// RL3: opcode 1Ah in byte 0 starts a mode report of configuration.
// RL4: descriptor-disable 0 includes block descriptor; 1 omits it.
// RL5: allocation length zero is valid and raises no error.
// RL6: reply cut to allocation length, even mid-field.
// RL7: page control 00 reports current values; saved after any reset. A hard_reset_evt while pclken is low is ignored here and leaves them.
// RL8: mode select ignored until spin-up completes.
// RL9: page control 01 returns mask, changeable fields all ones.
// RL10: page control 10 returns defaults, unsupported parameters zero.
// RL11: page control 11 returns saved values, else defaults.
// RL12: page codes 00h-1Ch return one page; 3Fh returns all pages. Only 00h and 3Fh are accepted here; other codes set the command error.
// RL13: reply order is header, block descriptors, then pages.
// RL14: four-byte header: length, medium, write-protect bit 7, descriptor length.
// RL15: eight-byte header: length msb first, medium, wp, zeros, descriptor length.
// RL16: data length counts following bytes; reserved on mode select.
// RL17: medium type always zero.
// RL18: write-protect zero in reports; reserved on mode select.
// RL19: select accepts descriptor length 0 or 8; report returns 8.
// RL20: each page length byte marks extent of supported fields.
// RL21: with descriptor omitted, descriptor length zero and data length reduced.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "mode_sense_defs.svh"

module mode_sense_log_responder (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclken,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// drive state
	input wire logic spinup_done,
	input wire logic hard_reset_evt,
	input wire logic [7:0] temperature,
	// reply status
	output logic reply_active
);
	logic [31:0] cmd_lo_r;
	logic [15:0] cmd_hi_r;
	logic [7:0] sense_code_r;
	logic [7:0] sense_qual_r;
	logic [7:0] trip_point_r;
	logic [31:0] blk_num_r;
	logic [23:0] blk_len_r;
	logic [15:0] cur_r;
	logic [15:0] saved_r;
	logic select_refused_r;
	logic cmd_error_r;
	mode_sense_pkg::reply_state_t state_r;
	logic hdr10_q_r;
	logic log_q_r;
	logic dbd_q_r;
	logic [1:0] pcf_q_r;
	logic [7:0] total_q_r;
	logic [7:0] send_len_r;
	logic [7:0] idx_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	// apb phases
	logic access_req;
	logic access_done;
	logic wr_done;
	logic rd_done;
	logic mapped;
	assign access_req = psel & penable & ~pready_r;
	assign access_done = psel & penable & pready_r;
	assign wr_done = access_done & pwrite & ~pslverr_r;
	assign rd_done = access_done & ~pwrite & ~pslverr_r;

	always_comb begin
		unique case (paddr)
			// holes in the map are refused with an error, not silently ignored
			`OFS_CMD_LO,
			`OFS_CMD_HI,
			`OFS_CTRL,
			`OFS_STATUS,
			`OFS_DATA,
			`OFS_SELECT,
			`OFS_SAVE,
			`OFS_SMART,
			`OFS_BLK_NUM,
			`OFS_BLK_LEN: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// decoded command fields
	logic [7:0] opcode;
	logic dbd;
	logic [1:0] pcf;
	logic [5:0] page_code;
	logic [7:0] alloc_len;
	logic start;
	logic page_ok;
	logic opc_ok;
	assign opcode = cmd_lo_r[7:0];
	assign dbd = cmd_lo_r[8 + `CMD_DBD_BIT];
	assign pcf = cmd_lo_r[23:22];
	assign page_code = cmd_lo_r[21:16];
	assign alloc_len = cmd_hi_r[7:0];
	assign start = wr_done & (paddr == `OFS_CTRL) & pwdata[`CTRL_START];
	// only the vendor page exists; the all-pages code returns it alone
	assign page_ok = (page_code == `PAGE_VENDOR) || (page_code == `PAGE_ALL); // see RL12
	assign opc_ok = (opcode == `OPC_MODE_SENSE6); // see RL3

	// available length of the reply about to start
	logic [7:0] avail;
	always_comb begin
		if (pwdata[`CTRL_LOG]) begin
			avail = `LOG_TOTAL_LEN;
		end else begin
			avail = (pwdata[`CTRL_HDR10] ? `HDR10_LEN : `HDR6_LEN)
				+ (dbd ? 8'h00 : `BLK_DESC_LEN) + `PAGE_TOTAL_LEN; // see RL13
		end
	end

	// page parameters chosen by page control
	logic [15:0] page_params;
	always_comb begin
		unique case (pcf_q_r)
			`PCF_CURRENT: page_params = cur_r; // see RL7
			`PCF_CHANGEABLE: page_params = `PARAM_CHANGE_MASK; // see RL9
			`PCF_DEFAULT: page_params = `PARAM_DEFAULT; // see RL10
			`PCF_SAVED: page_params = saved_r; // see RL11
		endcase
	end

	// one reply byte by position
	logic [7:0] mode_len;
	logic [7:0] bd_len;
	logic [7:0] hdr_len;
	logic [7:0] rel;
	logic [7:0] reply_byte;
	assign bd_len = dbd_q_r ? 8'h00 : `BLK_DESC_LEN; // see RL19 see RL21
	assign hdr_len = hdr10_q_r ? `HDR10_LEN : `HDR6_LEN;
	// length field excludes itself: one byte short form, two bytes long form
	assign mode_len = total_q_r - (hdr10_q_r ? `LEN10_FIELD : `LEN6_FIELD); // see RL16 see RL21

	always_comb begin
		reply_byte = 8'h00;
		rel = 8'h00;
		// temperature is live: the byte shows the reading at the moment it is read
		if (log_q_r) begin
			unique case (idx_r)
				8'h00: reply_byte = `LOG_PAGE_CODE; // see RL1
				8'h03: reply_byte = `LOG_PAGE_LEN; // see RL1
				8'h06: reply_byte = `LOG_FLAGS;
				8'h07: reply_byte = `LOG_PARAM_LEN; // see RL1
				8'h08: reply_byte = sense_code_r; // see RL2
				8'h09: reply_byte = sense_qual_r; // see RL2
				8'h0a: reply_byte = temperature; // see RL2
				8'h0b: reply_byte = trip_point_r; // see RL2
				default: reply_byte = 8'h00;
			endcase
		end else if (idx_r < hdr_len) begin
			if (hdr10_q_r) begin
				unique case (idx_r)
					8'h01: reply_byte = mode_len; // see RL15
					8'h02: reply_byte = `MEDIUM_TYPE; // see RL17
					8'h03: reply_byte = `WP_ENABLED; // see RL18
					8'h07: reply_byte = bd_len; // see RL15
					default: reply_byte = 8'h00;
				endcase
			end else begin
				unique case (idx_r)
					8'h00: reply_byte = mode_len; // see RL14
					8'h01: reply_byte = `MEDIUM_TYPE; // see RL17
					8'h02: reply_byte = `WP_ENABLED; // see RL14 see RL18
					8'h03: reply_byte = bd_len; // see RL14
					default: reply_byte = 8'h00;
				endcase
			end
		end else if (idx_r < hdr_len + bd_len) begin
			rel = idx_r - hdr_len; // see RL4
			unique case (rel)
				8'h00: reply_byte = blk_num_r[31:24];
				8'h01: reply_byte = blk_num_r[23:16];
				8'h02: reply_byte = blk_num_r[15:8];
				8'h03: reply_byte = blk_num_r[7:0];
				8'h04: reply_byte = `DENSITY_CODE;
				8'h05: reply_byte = blk_len_r[23:16];
				8'h06: reply_byte = blk_len_r[15:8];
				default: reply_byte = blk_len_r[7:0];
			endcase
		end else begin
			rel = idx_r - hdr_len - bd_len;
			unique case (rel)
				8'h00: reply_byte = `PAGE_PS_BIT | {2'h0, `PAGE_VENDOR};
				8'h01: reply_byte = `PAGE_BODY_LEN; // see RL20
				8'h02: reply_byte = page_params[15:8];
				default: reply_byte = page_params[7:0];
			endcase
		end
	end

	// register read mux
	logic [31:0] rd_nxt;
	always_comb begin
		rd_nxt = 32'h0000_0000;
		unique case (paddr)
			`OFS_CMD_LO: rd_nxt = cmd_lo_r;
			`OFS_CMD_HI: rd_nxt = {16'h0000, cmd_hi_r};
			`OFS_CTRL: rd_nxt = {29'h0000_0000, log_q_r, hdr10_q_r, 1'b0};
			`OFS_STATUS: rd_nxt = {8'h00, send_len_r, idx_r, 4'h0, select_refused_r,
				spinup_done, cmd_error_r, reply_active};
			`OFS_DATA: rd_nxt = (state_r == mode_sense_pkg::ST_SEND)
				? {23'h00_0000, 1'b1, reply_byte} : 32'h0000_0000;
			`OFS_SELECT: rd_nxt = {16'h0000, cur_r};
			`OFS_SAVE: rd_nxt = {16'h0000, saved_r};
			`OFS_SMART: rd_nxt = {8'h00, trip_point_r, sense_qual_r, sense_code_r};
			`OFS_BLK_NUM: rd_nxt = blk_num_r;
			`OFS_BLK_LEN: rd_nxt = {8'h00, blk_len_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// apb answer: one wait state, data and error held in flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (pclken) begin
			pready_r <= access_req;
			// the wait state lets read data come from a flop, not from the mux
			if (access_req) begin
				pslverr_r <= ~mapped;
				prdata_r <= (mapped && !pwrite) ? rd_nxt : 32'h0000_0000;
			end else if (access_done) begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// command and descriptor registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_lo_r <= 32'h0000_0000;
			cmd_hi_r <= 16'h0000;
			sense_code_r <= 8'h00;
			sense_qual_r <= 8'h00;
			trip_point_r <= 8'h00;
			blk_num_r <= 32'h0000_0000;
			blk_len_r <= 24'h00_0000;
		end else if (pclken && wr_done) begin
			if (paddr == `OFS_CMD_LO) begin
				cmd_lo_r <= pwdata;
			end
			if (paddr == `OFS_CMD_HI) begin
				cmd_hi_r <= pwdata[15:0];
			end
			// sense code and trip point come from firmware; temperature is a pin
			if (paddr == `OFS_SMART) begin
				sense_code_r <= pwdata[7:0];
				sense_qual_r <= pwdata[15:8];
				trip_point_r <= pwdata[23:16];
			end
			if (paddr == `OFS_BLK_NUM) begin
				blk_num_r <= pwdata;
			end
			if (paddr == `OFS_BLK_LEN) begin
				blk_len_r <= pwdata[23:0];
			end
		end
	end

	// select and save are refused until spinup_done shows that spin-up has completed
	logic refuse_set;
	logic refuse_clr;
	assign refuse_set = wr_done && (paddr == `OFS_SELECT || paddr == `OFS_SAVE)
		&& !spinup_done;
	assign refuse_clr = wr_done && paddr == `OFS_STATUS && pwdata[`STAT_REFUSED_BIT];

	// saved and current page values
	// no nonvolatile store here, so saved values start at the defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			saved_r <= `PARAM_DEFAULT;
			cur_r <= `PARAM_DEFAULT;
			select_refused_r <= 1'b0;
		end else if (pclken) begin
			if (wr_done && paddr == `OFS_SAVE && spinup_done) begin
				saved_r <= pwdata[15:0] & `PARAM_CHANGE_MASK; // see RL11
			end
			// a reset reload overrides a select landing in the same cycle
			if (hard_reset_evt) begin
				cur_r <= saved_r; // see RL7
			end else if (wr_done && paddr == `OFS_SELECT && spinup_done) begin
				cur_r <= (pwdata[15:0] & `PARAM_CHANGE_MASK)
					| (cur_r & ~`PARAM_CHANGE_MASK); // see RL7 see RL8
			end
			// refusal flag: a new refusal wins over a clear in the same cycle
			if (refuse_set) begin
				select_refused_r <= 1'b1; // see RL8
			end else if (refuse_clr) begin
				select_refused_r <= 1'b0;
			end
		end
	end

	// reply sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= mode_sense_pkg::ST_IDLE;
			hdr10_q_r <= 1'b0;
			log_q_r <= 1'b0;
			dbd_q_r <= 1'b0;
			pcf_q_r <= `PCF_CURRENT;
			total_q_r <= 8'h00;
			send_len_r <= 8'h00;
			idx_r <= 8'h00;
			cmd_error_r <= 1'b0;
			reply_active <= 1'b0;
		end else if (pclken) begin
			if (start) begin
				// fields latched so command writes during a reply cannot alter it
				hdr10_q_r <= pwdata[`CTRL_HDR10];
				log_q_r <= pwdata[`CTRL_LOG];
				dbd_q_r <= dbd; // see RL4
				pcf_q_r <= pcf;
				total_q_r <= avail;
				idx_r <= 8'h00;
				if (!pwdata[`CTRL_LOG] && !(opc_ok && page_ok)) begin
					cmd_error_r <= 1'b1;
					send_len_r <= 8'h00;
					state_r <= mode_sense_pkg::ST_IDLE;
					reply_active <= 1'b0;
				end else begin
					cmd_error_r <= 1'b0;
					// zero allocation simply sends nothing
					send_len_r <= (alloc_len < avail) ? alloc_len : avail; // see RL5 see RL6
					state_r <= (alloc_len == 8'h00) ? mode_sense_pkg::ST_IDLE
						: mode_sense_pkg::ST_SEND; // see RL5
					reply_active <= (alloc_len != 8'h00);
				end
			end else begin
				unique case (state_r)
					mode_sense_pkg::ST_IDLE: begin
						reply_active <= 1'b0;
					end
					mode_sense_pkg::ST_SEND: begin
						// index moves only on a completed read, so no byte is skipped
						if (rd_done && paddr == `OFS_DATA) begin
							idx_r <= idx_r + 8'h01;
							if (idx_r + 8'h01 >= send_len_r) begin
								state_r <= mode_sense_pkg::ST_IDLE; // see RL6
								reply_active <= 1'b0;
							end
						end
					end
				endcase
			end
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule

// ===== core/mode_sense_defs.svh
// constants for the mode sense and smart log responder
`ifndef MODE_SENSE_DEFS_SVH
`define MODE_SENSE_DEFS_SVH

// register byte offsets
`define OFS_CMD_LO 8'h00
`define OFS_CMD_HI 8'h04
`define OFS_CTRL 8'h08
`define OFS_STATUS 8'h0c
`define OFS_DATA 8'h10
`define OFS_SELECT 8'h14
`define OFS_SAVE 8'h18
`define OFS_SMART 8'h1c
`define OFS_BLK_NUM 8'h20
`define OFS_BLK_LEN 8'h24

// control and status bits
`define CTRL_START 0
`define CTRL_HDR10 1
`define CTRL_LOG 2
`define STAT_REFUSED_BIT 3

// command fields
`define OPC_MODE_SENSE6 8'h1a
`define CMD_DBD_BIT 3
`define PAGE_ALL 6'h3f
`define PAGE_SPECIFIC_MAX 6'h1c
`define PAGE_VENDOR 6'h00
`define PCF_CURRENT 2'h0
`define PCF_CHANGEABLE 2'h1
`define PCF_DEFAULT 2'h2
`define PCF_SAVED 2'h3

// reply sizes in bytes, and the page saveable bit
`define HDR6_LEN 8'h04
`define HDR10_LEN 8'h08
`define BLK_DESC_LEN 8'h08
`define PAGE_TOTAL_LEN 8'h04
`define PAGE_BODY_LEN 8'h02
`define PAGE_PS_BIT 8'h80
`define LOG_TOTAL_LEN 8'h0c
`define LEN6_FIELD 8'h01
`define LEN10_FIELD 8'h02

// smart log page
`define LOG_PAGE_CODE 8'h2f
`define LOG_PAGE_LEN 8'h08
`define LOG_PARAM_LEN 8'h04
`define LOG_FLAGS 8'h03

// header and block descriptor fixed fields
`define MEDIUM_TYPE 8'h00
`define WP_ENABLED 8'h00
`define DENSITY_CODE 8'h00

// vendor page parameters
`define PARAM_DEFAULT 16'h1121
`define PARAM_CHANGE_MASK 16'hff3f

`endif

// ===== core/mode_sense_pkg.sv
// types for the mode sense and smart log responder
package mode_sense_pkg;
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SEND
	} reply_state_t;
endpackage

// ===== tb/mode_sense_monitor.sv
// assertion checker for the mode sense and smart log responder
`timescale 1ns/1ns
`include "mode_sense_defs.svh"
module mode_sense_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// drive state and status
	input wire logic spinup_done,
	input wire logic reply_active
);
	logic [7:0] alloc_r;
	wire acc_w = psel && penable && pready;
	// last allocation length written, for the zero case
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			alloc_r <= 8'h00;
		else if (acc_w && pwrite && paddr == `OFS_CMD_HI)
			alloc_r <= pwdata[7:0];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held too long");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_UNMAPPED: assert property (acc_w && paddr > `OFS_BLK_LEN |-> pslverr)
		else $error("unmapped access not refused");
	AST_ERR_NO_DATA: assert property (pslverr |-> prdata == 32'h0)
		else $error("data on refused access");
	AST_ALLOC_ZERO: assert property (acc_w && pwrite && paddr == `OFS_CTRL && pwdata[0] &&
		alloc_r == 8'h00 |=> !reply_active [*3])
		else $error("reply started with zero length");
	AST_NO_SPARE_BYTE: assert property (acc_w && !pwrite && paddr == `OFS_DATA &&
		!reply_active |-> !prdata[8])
		else $error("byte given beyond reply");
	AST_SPINUP_STATUS: assert property (acc_w && !pwrite && paddr == `OFS_STATUS |->
		prdata[2] == $past(spinup_done))
		else $error("spin-up status wrong");
	AST_RISE_BY_START: assert property ($rose(reply_active) |->
		$past(psel && pwrite && paddr == `OFS_CTRL, 1) ||
		$past(psel && pwrite && paddr == `OFS_CTRL, 2))
		else $error("reply began without start");
	AST_FALL_BY_READ: assert property ($fell(reply_active) |->
		$past(psel && paddr == `OFS_DATA) || $past(psel && pwrite && paddr == `OFS_CTRL))
		else $error("reply ended without read");
	cover property (acc_w && paddr == `OFS_DATA && prdata[8]);
	cover property (pslverr);
	cover property ($fell(reply_active));
endmodule

bind mode_sense_log_responder mode_sense_monitor chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .spinup_done(spinup_done),
	.reply_active(reply_active));

// ===== tb/initiator_model.sv
// apb master standing in for the initiator host adapter
`timescale 1ns/1ns
module initiator_model (
	// clock
	input wire logic pclk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// called just after an edge; request held until ready is seen
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge pclk);
	endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench for the mode sense and smart log responder
`timescale 1ns/1ns
`include "mode_sense_defs.svh"
module testbench;
	logic pclk, presetn, pclken, spinup_done, hard_reset_evt;
	logic psel, penable, pwrite, pready, pslverr, reply_active;
	logic [7:0] paddr, temperature;
	logic [31:0] pwdata, prdata, bn, bl, rnd;
	logic [32:0] exp_q[$], msk_q[$];
	logic [7:0] rep[$];
	logic [15:0] cur, sav;
	int err_count = 0;
	int num_checks = 0;
	mode_sense_log_responder dut_u (.pclk(pclk), .presetn(presetn), .pclken(pclken),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .spinup_done(spinup_done),
		.hard_reset_evt(hard_reset_evt), .temperature(temperature),
		.reply_active(reply_active));
	initiator_model mdl_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready));
	function automatic logic [31:0] xs();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd;
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e, input logic [32:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		mdl_u.xfer(w, a, d);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, a, d, 33'h0, {33{1'b1}});
	endtask
	// starts a reply and drains it, one probe past the end
	task automatic sense(input logic [31:0] lo, input logic [7:0] al, input logic [2:0] ctl);
		int n;
		wr(`OFS_CMD_LO, lo);
		wr(`OFS_CMD_HI, {24'h0, al});
		wr(`OFS_CTRL, {29'h0, ctl});
		n = (al < rep.size()) ? al : rep.size();
		for (int i = 0; i < n; i++)
			acc(1'b0, `OFS_DATA, 32'h0, {24'h1, rep[i]}, 33'h1ff);
		acc(1'b0, `OFS_DATA, 32'h0, 33'h0, 33'h100);
	endtask
	task automatic mode(input logic [1:0] pcf, input logic dbd, input logic h10,
		input logic [5:0] pg, input logic [7:0] al);
		logic [15:0] v;
		logic [7:0] bd, tot;
		v = pcf == 2'h0 ? cur : pcf == 2'h1 ? 16'hff3f : pcf == 2'h2 ? 16'h1121 : sav;
		bd = dbd ? 8'h00 : 8'h08;
		tot = (h10 ? 8'h08 : 8'h04) + bd + 8'h04;
		if (h10)
			rep = {8'h00, tot - 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, bd};
		else
			rep = {tot - 8'h01, 8'h00, 8'h00, bd};
		if (!dbd)
			rep = {rep, bn[31:24], bn[23:16], bn[15:8], bn[7:0], 8'h00, bl[23:16], bl[15:8], bl[7:0]};
		rep = {rep, 8'h80, 8'h02, v[15:8], v[7:0]};
		sense({8'h00, pcf, pg, 4'h0, dbd, 3'h0, 8'h1a}, al, {1'b0, h10, 1'b1});
	endtask
	task automatic logp(input logic [7:0] al);
		logic [31:0] s;
		s = xs();
		temperature <= s[31:24];
		wr(`OFS_SMART, s);
		rep = {8'h2f, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h03, 8'h04,
			s[7:0], s[15:8], s[31:24], s[23:16]};
		sense(32'h0, al, 3'h5);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// result watcher: oldest note against each answer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1)
			check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
	end
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#500000;
		err_count++;
		results();
	end
	initial begin
		presetn = 1'b0;
		spinup_done = 1'b0;
		hard_reset_evt = 1'b0;
		pclken = 1'b1;
		temperature = 8'h2a;
		rnd = 32'h62;
		cur = 16'h1121;
		sav = 16'h1121;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		wr(`OFS_SELECT, 32'h5a0c);
		acc(1'b0, `OFS_SELECT, 32'h0, {17'h0, cur}, {33{1'b1}});
		acc(1'b0, `OFS_STATUS, 32'h0, 33'h8, 33'hc);
		spinup_done <= 1'b1;
		wr(`OFS_STATUS, 32'h8);
		acc(1'b0, `OFS_STATUS, 32'h0, 33'h4, 33'hc);
		bn = xs();
		bl = xs();
		wr(`OFS_BLK_NUM, bn);
		wr(`OFS_BLK_LEN, {8'h00, bl[23:0]});
		acc(1'b0, 8'h30, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
		// every page control, descriptor and header form; random lengths cut replies
		for (int i = 0; i < 16; i++)
			mode(i[1:0], i[2], i[3], i[0] ? `PAGE_ALL : 6'h00, i == 0 ? 8'h00 : 8'(xs() % 22));
		wr(`OFS_SELECT, 32'h5a0c);
		cur = 16'h5a0c;
		// enable low: a reload request must leave the current values alone
		pclken <= 1'b0;
		hard_reset_evt <= 1'b1;
		@(posedge pclk);
		pclken <= 1'b1;
		hard_reset_evt <= 1'b0;
		acc(1'b0, `OFS_SELECT, 32'h0, {17'h0, cur}, {33{1'b1}});
		mode(2'h0, 1'b1, 1'b0, 6'h00, 8'hff);
		mode(2'h3, 1'b1, 1'b1, 6'h00, 8'hff);
		hard_reset_evt <= 1'b1;
		@(posedge pclk);
		hard_reset_evt <= 1'b0;
		cur = sav;
		mode(2'h0, 1'b0, 1'b0, `PAGE_ALL, 8'hff);
		wr(`OFS_SAVE, 32'hc3e7);
		sav = 16'hc327;
		mode(2'h3, 1'b0, 1'b1, `PAGE_ALL, 8'h14);
		hard_reset_evt <= 1'b1;
		@(posedge pclk);
		hard_reset_evt <= 1'b0;
		cur = sav;
		acc(1'b0, `OFS_SELECT, 32'h0, {17'h0, cur}, {33{1'b1}});
		wr(`OFS_CMD_LO, {8'h00, 2'h0, 6'h05, 8'h00, 8'h1a});
		wr(`OFS_CTRL, 32'h1);
		acc(1'b0, `OFS_STATUS, 32'h0, 33'h2, 33'h3);
		logp(8'h0c);
		logp(8'(xs() % 12));
		// power-on again: saved and current fall back to the defaults
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		acc(1'b0, `OFS_SELECT, 32'h0, {17'h0, 16'h1121}, {33{1'b1}});
		acc(1'b0, `OFS_SAVE, 32'h0, {17'h0, 16'h1121}, {33{1'b1}});
		results();
	end
endmodule
